// file: verilog/pulse_trig_map.svh
// constants for the pulse-class trigger qualifier
`ifndef PULSE_TRIG_MAP_SVH
`define PULSE_TRIG_MAP_SVH

// counter width for widths, slew intervals and timeouts
`define PTD_CNT_W 24
// width of the trigger event tally
`define PTD_EVT_W 16
// reset value of the comparator history
`define PTD_CMP_RST 3'h0
// reset value of a single control flop
`define PTD_BIT_RST 1'h0

`endif

// file: verilog/pulse_trig_pkg.sv
// types shared by the pulse-class trigger qualifier
`default_nettype none
package pulse_trig_pkg;

  typedef enum logic [2:0] {
    CLS_GLITCH,
    CLS_RUNT,
    CLS_WIDTH,
    CLS_SLEW,
    CLS_TIMEOUT
  } trigClass_t;

  typedef enum logic [1:0] {
    POL_POS,
    POL_NEG,
    POL_EITHER
  } pol_t;

  // threshold comparator outputs of one channel
  typedef struct packed {
    logic aboveHigh;
    logic aboveLevel;
    logic aboveLow;
  } chanCmp_t;

  typedef struct packed {
    trigClass_t cls;
    pol_t       pol;
    logic [1:0] src;
    logic       glitchReject;
    logic       widthOutside;
    logic       slewSlower;
  } trigCfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } edges_t;

  typedef enum logic [1:0] {
    RUNT_IDLE,
    RUNT_UP,
    RUNT_DOWN
  } runtState_t;

  typedef enum logic [1:0] {
    SLEW_IDLE,
    SLEW_RISE,
    SLEW_FALL
  } slewState_t;

endpackage : pulse_trig_pkg
`default_nettype wire

// file: verilog/interval_counter.sv
// saturating cycle counter that restarts at one
`timescale 1ns/1ns
`default_nettype none
`include "pulse_trig_map.svh"
module interval_counter #(
  parameter int W = `PTD_CNT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // control
  input  wire logic         restart,
  // cycles since the last restart
  output logic [W-1:0] count
);

  localparam logic [W-1:0] ONE = W'(1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         atMax;

  // saturate rather than wrap so a long hold never looks short
  assign atMax = &cnt_q;
  assign cnt_d = restart ? ONE : (atMax ? cnt_q : cnt_q + ONE);
  assign count = cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : interval_counter
`default_nettype wire

// file: verilog/pulse_trigger_detector.sv
// pulse-class trigger qualifier: glitch, runt, width, slew, timeout
`timescale 1ns/1ns
`default_nettype none
`include "pulse_trig_map.svh"

//
// Function
// - glitch positive: fire on a high pulse narrower than the glitch limit
// - glitch negative: fire on a low pulse narrower than the glitch limit
// - glitch either: fire on a narrow pulse of either polarity
// - glitch reject inverts qualification so narrow pulses are ignored
// - accept fires only below the limit, reject only above it
// - positive runt: up through low, back down, never crossing high
// - negative runt: down through high, back up, never reaching low
// - either runt: cross one threshold, return, never cross the other
// - runt fires when the pulse recrosses its first threshold
// - width positive: fire on a high pulse meeting the limits
// - width negative: fire on a low pulse meeting the limits
// - width inside selects between limits, outside selects beyond them
// - positive slew timed from low crossing up to high crossing
// - negative slew timed from high crossing down to low crossing
// - either slew timed from first crossing to the other threshold
// - slew fires only if faster, or slower, than the programmed limit
// - timeout high: fire when held above level longer than limit
// - timeout low: fire when held below level longer than limit
// - timeout either: fire when no edge occurs for the limit
// - one source of four channels feeds every pulse class
module pulse_trigger_detector
  import pulse_trig_pkg::*;
#(
  parameter int CNT_W = `PTD_CNT_W,
  parameter int EVT_W = `PTD_EVT_W
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // comparator outputs of the four channels
  input  wire chanCmp_t [3:0]      chans,
  // class, polarity, source and option bits
  input  wire trigCfg_t            cfg,
  // programmed limits in clock cycles
  input  wire logic [CNT_W-1:0]    glitchLimit,
  input  wire logic [CNT_W-1:0]    widthLower,
  input  wire logic [CNT_W-1:0]    widthUpper,
  input  wire logic [CNT_W-1:0]    slewLimit,
  input  wire logic [CNT_W-1:0]    timeoutLimit,
  // trigger event and status
  output logic                     trigFire,
  output logic [EVT_W-1:0]         trigTotal,
  output logic [CNT_W-1:0]         trigMeasure,
  output logic                     edgeSeen
);

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [EVT_W-1:0] EVT_ONE = EVT_W'(1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic edges_t edgeOf(input logic cur,
                                    input logic prev,
                                    input logic ok);
    edges_t e;
    e.rise = ok & cur & ~prev;
    e.fall = ok & ~cur & prev;
    return e;
  endfunction : edgeOf

  // ----------------------------------------------------------------
  // source selection and edge history
  // ----------------------------------------------------------------
  chanCmp_t   srcNow;
  chanCmp_t   prev_q;
  logic [1:0] src_q;
  logic       primed_q;
  logic       seen_q;
  logic       srcChg;

  assign srcNow = chans[cfg.src];
  // history of another channel must not look like an edge
  assign srcChg = (cfg.src != src_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q   <= `PTD_CMP_RST;
      src_q    <= 2'h0;
      primed_q <= `PTD_BIT_RST;
    end else begin
      prev_q   <= srcNow;
      src_q    <= cfg.src;
      primed_q <= ~srcChg;
    end
  end

  edges_t lvlE;
  edges_t lowE;
  edges_t highE;
  logic   edgeOk;
  logic   lvlEdge;

  assign edgeOk  = primed_q & ~srcChg;
  assign lvlE    = edgeOf(srcNow.aboveLevel, prev_q.aboveLevel, edgeOk);
  assign lowE    = edgeOf(srcNow.aboveLow, prev_q.aboveLow, edgeOk);
  assign highE   = edgeOf(srcNow.aboveHigh, prev_q.aboveHigh, edgeOk);
  assign lvlEdge = lvlE.rise | lvlE.fall;

  // a pulse width is only trusted once its start edge was seen
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= `PTD_BIT_RST;
    end else begin
      seen_q <= ~srcChg & (seen_q | lvlEdge);
    end
  end

  // ----------------------------------------------------------------
  // interval counters
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] lvlCnt;
  logic [CNT_W-1:0] bandCnt;
  logic             lvlRestart;
  logic             bandRestart;

  assign lvlRestart  = lvlEdge | srcChg;
  // entry crossings of the threshold band start runt and slew timing
  assign bandRestart = lowE.rise | highE.fall | srcChg;

  interval_counter #(.W(CNT_W)) u_lvlTimer (
    .clk     (clk),
    .arst_n  (arst_n),
    .restart (lvlRestart),
    .count   (lvlCnt)
  );

  interval_counter #(.W(CNT_W)) u_bandTimer (
    .clk     (clk),
    .arst_n  (arst_n),
    .restart (bandRestart),
    .count   (bandCnt)
  );

  // ----------------------------------------------------------------
  // polarity and pulse end
  // ----------------------------------------------------------------
  logic polPos;
  logic polNeg;
  logic pulseEnd;

  assign polPos   = (cfg.pol == POL_POS) | (cfg.pol == POL_EITHER);
  assign polNeg   = (cfg.pol == POL_NEG) | (cfg.pol == POL_EITHER);
  // a high pulse ends on the falling edge, a low one on the rising edge
  assign pulseEnd = seen_q & ((lvlE.fall & polPos)
                   | (lvlE.rise & polNeg));

  // ----------------------------------------------------------------
  // glitch and width
  // ----------------------------------------------------------------
  logic gNarrow;
  logic gWide;
  logic glitchHit;
  logic inRange;
  logic widthHit;

  assign gNarrow   = lvlCnt < glitchLimit;
  assign gWide     = lvlCnt > glitchLimit;
  assign glitchHit = pulseEnd
                   & (cfg.glitchReject ? gWide : gNarrow);
  assign inRange   = (lvlCnt >= widthLower) & (lvlCnt <= widthUpper);
  assign widthHit  = pulseEnd
                   & (cfg.widthOutside ? ~inRange : inRange);

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  logic             toOver;
  logic             toAt;
  logic             timeoutHit;
  logic [CNT_W-1:0] toPlus;

  // a limit at full scale wraps toPlus to zero, so it can fire only in the first cycle after reset
  assign toPlus = timeoutLimit + CNT_ONE;
  assign toOver = ~lvlEdge & (lvlCnt == toPlus);
  assign toAt   = ~lvlEdge & (lvlCnt == timeoutLimit);
  always_comb begin
    case (cfg.pol)
      POL_POS:    timeoutHit = toOver & srcNow.aboveLevel;
      POL_NEG:    timeoutHit = toOver & ~srcNow.aboveLevel;
      POL_EITHER: timeoutHit = toAt;
      default:    timeoutHit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // runt
  // ----------------------------------------------------------------
  runtState_t runt_q;
  runtState_t runt_d;
  logic       runtHit;

  always_comb begin
    runt_d  = runt_q;
    runtHit = 1'b0;
    case (runt_q)
      RUNT_IDLE: begin
        if (polPos & lowE.rise & ~highE.rise) begin
          runt_d = RUNT_UP;
        end else if (polNeg & highE.fall & ~lowE.fall) begin
          runt_d = RUNT_DOWN;
        end
      end
      RUNT_UP: begin
        if (highE.rise) begin
          runt_d = RUNT_IDLE;
        end else if (lowE.fall) begin
          runtHit = 1'b1;
          runt_d  = RUNT_IDLE;
        end
      end
      RUNT_DOWN: begin
        if (lowE.fall) begin
          runt_d = RUNT_IDLE;
        end else if (highE.rise) begin
          runtHit = 1'b1;
          runt_d  = RUNT_IDLE;
        end
      end
      default: runt_d = RUNT_IDLE;
    endcase
    if (srcChg) begin
      runt_d = RUNT_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // slew
  // ----------------------------------------------------------------
  slewState_t       slew_q;
  slewState_t       slew_d;
  logic             slewDone;
  logic [CNT_W-1:0] slewTime;
  logic             slewHit;

  // both thresholds crossed in one sample counts as zero cycles
  always_comb begin
    slew_d   = slew_q;
    slewDone = 1'b0;
    slewTime = '0;
    case (slew_q)
      SLEW_IDLE: begin
        if (polPos & lowE.rise) begin
          slewDone = highE.rise;
          slew_d   = highE.rise ? SLEW_IDLE : SLEW_RISE;
        end else if (polNeg & highE.fall) begin
          slewDone = lowE.fall;
          slew_d   = lowE.fall ? SLEW_IDLE : SLEW_FALL;
        end
      end
      SLEW_RISE: begin
        if (highE.rise) begin
          slewDone = 1'b1;
          slewTime = bandCnt;
          slew_d   = SLEW_IDLE;
        end else if (lowE.fall) begin
          slew_d = SLEW_IDLE;
        end
      end
      SLEW_FALL: begin
        if (lowE.fall) begin
          slewDone = 1'b1;
          slewTime = bandCnt;
          slew_d   = SLEW_IDLE;
        end else if (highE.rise) begin
          slew_d = SLEW_IDLE;
        end
      end
      default: slew_d = SLEW_IDLE;
    endcase
    if (srcChg) begin
      slew_d = SLEW_IDLE;
    end
  end

  // shorter transit time means a faster edge
  assign slewHit = slewDone & (cfg.slewSlower ? (slewTime > slewLimit)
                                              : (slewTime < slewLimit));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      runt_q <= RUNT_IDLE;
      slew_q <= SLEW_IDLE;
    end else begin
      runt_q <= runt_d;
      slew_q <= slew_d;
    end
  end

  // ----------------------------------------------------------------
  // class selection and outputs
  // ----------------------------------------------------------------
  logic             fire;
  logic [CNT_W-1:0] measure;
  logic             fire_q;
  logic [EVT_W-1:0] total_q;
  logic [CNT_W-1:0] meas_q;

  assign fire = ((cfg.cls == CLS_GLITCH)  & glitchHit)
              | ((cfg.cls == CLS_RUNT)    & runtHit)
              | ((cfg.cls == CLS_WIDTH)   & widthHit)
              | ((cfg.cls == CLS_SLEW)    & slewHit)
              | ((cfg.cls == CLS_TIMEOUT) & timeoutHit);
  // runt reports its time inside the band
  assign measure = (cfg.cls == CLS_SLEW) ? slewTime
                 : (cfg.cls == CLS_RUNT) ? bandCnt
                 : lvlCnt;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fire_q  <= `PTD_BIT_RST;
      total_q <= '0;
      meas_q  <= '0;
    end else begin
      fire_q  <= fire;
      total_q <= fire ? total_q + EVT_ONE : total_q;
      meas_q  <= fire ? measure : meas_q;
    end
  end

  assign trigFire    = fire_q;
  assign trigTotal   = total_q;
  assign trigMeasure = meas_q;
  assign edgeSeen    = seen_q;

endmodule : pulse_trigger_detector
`default_nettype wire

// file: sim/front_end_model.sv
// comparator front end model for the trigger qualifier
`timescale 1ns/1ns
`default_nettype none
module front_end_model
  import pulse_trig_pkg::*;
(
  // amplitude step: 0 low, 1 band, 2 level, 3 high
  input  wire logic [3:0][1:0] amp,
  // threshold flags
  output var chanCmp_t [3:0]   chans
);
  // thresholds are ordered, so the flags always nest
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chans[i].aboveLow   = amp[i] >= 2'h1;
      chans[i].aboveLevel = amp[i] >= 2'h2;
      chans[i].aboveHigh  = amp[i] == 2'h3;
    end
  end
endmodule : front_end_model
`default_nettype wire

// file: sim/pulse_trigger_detector_properties.sv
// timing checks on the trigger qualifier ports
`timescale 1ns/1ns
`default_nettype none
module pulse_trigger_detector_properties
  import pulse_trig_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int EVT_W = 16
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             arst_n,
  // watched inputs
  input wire chanCmp_t [3:0]   chans,
  input wire trigCfg_t         cfg,
  input wire logic [CNT_W-1:0] glitchLimit,
  input wire logic [CNT_W-1:0] widthLower,
  input wire logic [CNT_W-1:0] widthUpper,
  // watched outputs
  input wire logic             trigFire,
  input wire logic [EVT_W-1:0] trigTotal,
  input wire logic [CNT_W-1:0] trigMeasure,
  input wire logic             edgeSeen
);
  trigCfg_t cfgQ;
  wire chanCmp_t s = chans[cfg.src];
  // a fire is only judged when the settings did not move under it
  wire logic calm = trigFire && cfg == cfgQ;
  wire logic inRange = trigMeasure >= widthLower && trigMeasure <= widthUpper;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cfgQ <= '0;
    else cfgQ <= cfg;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_total_step: assert property (trigFire |->
    trigTotal == $past(trigTotal) + 1'h1) else $error("tally no step");
  a_result_hold: assert property (!trigFire |->
    $stable(trigTotal) && $stable(trigMeasure)) else $error("result moved");
  a_accept_narrow: assert property (calm && cfg.cls == CLS_GLITCH &&
    !cfg.glitchReject |-> trigMeasure < glitchLimit) else $error("wide");
  a_reject_wide: assert property (calm && cfg.cls == CLS_GLITCH &&
    cfg.glitchReject |-> trigMeasure > glitchLimit) else $error("narrow");
  a_width_inside: assert property (calm && cfg.cls == CLS_WIDTH &&
    !cfg.widthOutside |-> inRange) else $error("width outside");
  a_width_outside: assert property (calm && cfg.cls == CLS_WIDTH &&
    cfg.widthOutside |-> !inRange) else $error("width inside");
  a_glitch_fall: assert property (calm && cfg.cls == CLS_GLITCH &&
    cfg.pol == POL_POS |-> $past(s.aboveLevel, 2) && !$past(s.aboveLevel))
    else $error("glitch not on fall");
  a_runt_recross: assert property (calm && cfg.cls == CLS_RUNT &&
    cfg.pol == POL_POS |-> $past(s.aboveLow, 2) && !$past(s.aboveLow))
    else $error("runt not on recross");
  a_timeout_high: assert property (calm && cfg.cls == CLS_TIMEOUT &&
    cfg.pol == POL_POS |-> $past(s.aboveLevel)) else $error("not held");
  a_slew_rise: assert property (calm && cfg.cls == CLS_SLEW &&
    cfg.pol == POL_POS |-> $past(s.aboveHigh) && !$past(s.aboveHigh, 2))
    else $error("slew not on high cross");
  a_source_clear: assert property (cfg.src != $past(cfg.src) |=>
    !edgeSeen) else $error("edge flag kept");
  c_runt: cover property (trigFire && cfg.cls == CLS_RUNT);
  c_reject: cover property (trigFire && cfg.glitchReject);
  c_timeout: cover property (trigFire && cfg.cls == CLS_TIMEOUT);
endmodule : pulse_trigger_detector_properties
bind pulse_trigger_detector pulse_trigger_detector_properties
  #(.CNT_W(CNT_W), .EVT_W(EVT_W)) pulse_trigger_detector_properties_inst (
  .clk, .arst_n, .chans, .cfg, .glitchLimit, .widthLower, .widthUpper,
  .trigFire, .trigTotal, .trigMeasure, .edgeSeen);
`default_nettype wire

// file: sim/test_pulse_trigger_detector.sv
// self-checking bench for the trigger qualifier
`timescale 1ns/1ns
`default_nettype none
module test_pulse_trigger_detector
  import pulse_trig_pkg::*;
;
  localparam int CW = 8;
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [3:0][1:0] amp;
  logic [3:0][1:0] rndAmp = '0;
  logic [1:0]      sel = 2'h0;
  logic [1:0]      srcSel = 2'h3;
  chanCmp_t [3:0]  chans;
  trigCfg_t        cfg = '0;
  logic            trigFire;
  logic            edgeSeen;
  logic [15:0]     trigTotal;
  logic [CW-1:0]   trigMeasure;
  logic [31:0]     seed = 32'h4B;
  int failures = 0;
  int checked = 0;
  int fires = 0;
  // cls pol opt base mid midW peak W fires measure (-1: not judged)
  int t[22][10] = '{
    '{0,0,0,0,0,0,2,2,1,2},
    '{0,0,0,0,0,0,2,3,0,-1},
    '{0,1,0,2,0,0,0,2,1,2},
    '{0,2,0,0,0,0,2,2,1,2},
    '{0,0,4,0,0,0,2,5,1,5},
    '{0,0,4,0,0,0,2,2,0,-1},
    '{1,0,0,0,0,0,1,4,1,4},
    '{1,0,0,0,0,0,3,4,0,-1},
    '{1,1,0,3,0,0,2,3,1,3},
    '{1,2,0,0,0,0,1,2,1,2},
    '{2,0,0,0,0,0,2,4,1,4},
    '{2,0,0,0,0,0,2,6,0,-1},
    '{2,0,2,0,0,0,2,6,1,6},
    '{2,1,0,2,0,0,0,4,1,4},
    '{3,0,0,0,1,1,3,4,1,1},
    '{3,0,0,0,1,4,3,4,0,-1},
    '{3,0,1,0,1,4,3,4,1,4},
    '{3,1,0,3,1,1,0,4,1,1},
    '{3,2,0,0,1,1,3,4,2,0},
    '{4,0,0,0,0,0,2,12,1,7},
    '{4,1,0,2,0,0,0,12,1,7},
    '{4,2,0,0,0,0,2,12,2,6}
  };

  // limits shared by the instance and the reference model
  localparam int GL   = 3;
  localparam int WLO  = 3;
  localparam int WHI  = 5;
  localparam int TO   = 6;
  localparam int CMAX = (1 << CW) - 1;
  int         runLen = 0;
  int         expQ[$];
  bit         known = 1'b0;
  bit         lvlPrev = 1'b0;
  logic [1:0] srcPrev = 2'h0;

  always #10 clk = ~clk;

  // unselected channels carry noise that must never reach a trigger
  always_comb begin
    amp = rndAmp;
    amp[srcSel] = sel;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  always @(negedge clk) begin
    seed = xs(seed);
    rndAmp <= seed[7:0];
  end

  always @(negedge clk) if (trigFire === 1'b1) fires++;

  // reference model of the level run on the selected source; one
  // expectation per edge for glitch, width and timeout, judged a
  // half cycle after the edge that registers the design's answer
  always @(posedge clk) begin : model
    bit lvl;
    bit hit;
    bit endOk;
    bit judged;
    lvl    = (sel >= 2'h2);
    hit    = 1'b0;
    // a high run ends on a fall, a low run on a rise
    endOk  = lvl ? (cfg.pol == POL_NEG || cfg.pol == POL_EITHER)
                 : (cfg.pol == POL_POS || cfg.pol == POL_EITHER);
    judged = (cfg.cls == CLS_GLITCH) || (cfg.cls == CLS_WIDTH)
           || (cfg.cls == CLS_TIMEOUT);
    if (!arst_n) begin
      runLen  = 0;
      known   = 1'b0;
      lvlPrev = 1'b0;
      srcPrev = 2'h0;
    end else if (cfg.src != srcPrev) begin
      runLen  = 1;
      known   = 1'b0;
      lvlPrev = lvl;
      srcPrev = cfg.src;
    end else if (lvl != lvlPrev) begin
      if (cfg.cls == CLS_GLITCH) begin
        hit = cfg.glitchReject ? (runLen > GL) : (runLen < GL);
      end else if (cfg.cls == CLS_WIDTH) begin
        hit = ((runLen >= WLO) && (runLen <= WHI)) != cfg.widthOutside;
      end
      hit = hit && known && endOk;
      if (judged) expQ.push_back(hit ? runLen : -1);
      runLen  = 1;
      known   = 1'b1;
      lvlPrev = lvl;
    end else begin
      if (cfg.cls == CLS_TIMEOUT) begin
        if (cfg.pol == POL_EITHER) hit = (runLen == TO);
        else hit = (runLen == TO + 1) && (lvl == (cfg.pol == POL_POS));
      end
      if (judged) expQ.push_back(hit ? runLen : -1);
      if (runLen < CMAX) runLen++;
    end
  end

  always @(negedge clk) begin : judge
    int e;
    if (expQ.size() > 0) begin
      e = expQ.pop_front();
      chk("model fire", trigFire, e >= 0);
      if (e >= 0) chk("model measure", trigMeasure, e);
    end
  end

  front_end_model front_end_model_inst (.amp(amp), .chans(chans));

  pulse_trigger_detector #(.CNT_W(CW)) pulse_trigger_detector_inst (
    .clk(clk), .arst_n(arst_n), .chans(chans), .cfg(cfg),
    .glitchLimit(CW'(GL)), .widthLower(CW'(WLO)), .widthUpper(CW'(WHI)),
    .slewLimit(8'h03), .timeoutLimit(CW'(TO)), .trigFire(trigFire),
    .trigTotal(trigTotal), .trigMeasure(trigMeasure), .edgeSeen(edgeSeen));

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  task run(input int r[10]);
    int f0;
    logic [15:0] t0;
    @(negedge clk);
    cfg = '{trigClass_t'(r[0]), pol_t'(r[1]), srcSel, r[2][2], r[2][1], r[2][0]};
    sel = r[3][1:0];
    repeat (10) @(negedge clk);
    f0 = fires;
    t0 = trigTotal;
    if (r[5] > 0) begin
      sel = r[4][1:0];
      repeat (r[5]) @(negedge clk);
    end
    sel = r[6][1:0];
    repeat (r[7]) @(negedge clk);
    sel = r[3][1:0];
    repeat (10) @(negedge clk);
    #5;
    chk("fire pulses", fires - f0, r[8]);
    chk("trigger tally", 16'(trigTotal - t0), r[8]);
    if (r[9] >= 0) chk("measure", trigMeasure, r[9]);
  endtask : run

  initial begin
    #100000;
    failures++;
    end_sim;
  end

  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    for (int i = 0; i < 22; i++) begin
      run(t[i]);
      $display("test %0d done", i);
    end
    @(negedge clk);
    srcSel = 2'h1;
    cfg.src = 2'h1;
    repeat (2) @(negedge clk);
    chk("edge flag", edgeSeen, 1'b0);
    run(t[0]);
    chk("edge flag", edgeSeen, 1'b1);
    $display("test source done");
    end_sim;
  end
endmodule : test_pulse_trigger_detector
`default_nettype wire
